// ### rtl/nvmcwp_gate.sv
// access gate between cpu / external tool and the nonvolatile arrays
// assumes arrays answer in the same cycle as a forwarded read; config pins come from fuses
`timescale 1ns/100ps
module nvmcwp_gate (
    input wire logic clock, // system clock, 125 MHz
    input wire logic rst, // synchronous reset, active high
    input wire nvmcwp_pkg::nvmcwp_cfg_t cfgIn, // configuration word bits from fuses
    input wire nvmcwp_pkg::nvmcwp_req_t extReq, // external tool request
    input wire nvmcwp_pkg::nvmcwp_req_t cpuReq, // cpu request
    input wire logic [nvmcwp_pkg::DATA_W-1:0] pmRdata, // program array read data
    input wire logic [nvmcwp_pkg::DATA_W-1:0] eeRdata, // eeprom array read data
    output nvmcwp_pkg::nvmcwp_req_t pmReq, // forwarded program array request
    output nvmcwp_pkg::nvmcwp_req_t eeReq, // forwarded eeprom request
    output logic [nvmcwp_pkg::DATA_W-1:0] extRdata, // external read answer
    output logic extRvalid, // external answer valid pulse
    output logic extRefused, // external access refused pulse
    output logic [nvmcwp_pkg::DATA_W-1:0] cpuRdata, // cpu read answer
    output logic cpuRvalid, // cpu answer valid pulse
    output logic cpuWrRefused // cpu self-write refused pulse
);
    import nvmcwp_pkg::*;
    // ******************************************************
    // decode helpers
    // ******************************************************
    function automatic logic isEe(input logic [ADDR_W-1:0] a); // eeprom window
        return (a >= EE_BASE) && (a <= EE_LAST);
    endfunction : isEe
    function automatic logic isUid(input logic [ADDR_W-1:0] a); // user id words
        return (a >= USER_ID_BASE) && (a <= USER_ID_LAST);
    endfunction : isUid
    function automatic logic isId(input logic [ADDR_W-1:0] a); // fixed id words
        return (a == DEV_ID_ADDR) || (a == REV_ID_ADDR);
    endfunction : isId
    function automatic logic isPm(input logic [ADDR_W-1:0] a); // program space
        return !a[ADDR_W-1];
    endfunction : isPm

    // ******************************************************
    // configuration capture
    // ******************************************************
    nvmcwp_cfg_t cfg_r; // held configuration
    logic cfgLoad_r; // one-shot load after reset release
    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_r <= '0;
            cfgLoad_r <= 1'b1;
        end else if (cfgLoad_r) begin
            cfg_r <= cfgIn;
            cfgLoad_r <= 1'b0;
        end
    end
    // until loaded, cfgLoad_r keeps external program and eeprom access and cpu program writes locked

    // ******************************************************
    // access decisions
    // ******************************************************
    wire extPmOk = cfg_r.programProtect_n && !cfgLoad_r;
    wire extEeOk = cfg_r.dataProtect_n && !cfgLoad_r;
    wire extAny = extReq.rd || extReq.wr; // external strobe
    wire cpuAny = cpuReq.rd || cpuReq.wr; // cpu strobe
    wire extIsEe = isEe(extReq.addr); // external eeprom target
    wire extIsPm = isPm(extReq.addr); // external program target
    wire extIsUid = isUid(extReq.addr); // external user id target
    wire extIsId = isId(extReq.addr); // external fixed id target
    wire cpuIsEe = isEe(cpuReq.addr); // cpu eeprom target
    wire cpuIsPm = isPm(cpuReq.addr); // cpu program target
    wire cpuIsUid = isUid(cpuReq.addr); // cpu user id target
    logic [ADDR_W-1:0] guardEnd; // end of self-write guarded block
    always_comb begin
        case (cfg_r.selfWriteGuardSize)
            2'h0: guardEnd = GUARD_END_0;
            2'h1: guardEnd = GUARD_END_1;
            2'h2: guardEnd = GUARD_END_2;
            default: guardEnd = 16'h0000;
        endcase
    end
    // guard uses only the write-guard field, never the code-protect bit
    wire cpuInGuard = (cfg_r.selfWriteGuardSize != GUARD_OFF)
        && (cpuReq.addr < guardEnd);
    wire cpuPmWrOk = cpuReq.wr && cpuIsPm && !cpuInGuard && !cfgLoad_r;
    // external refusal: program or eeprom locked; fixed id reads never refused, writes refused
    wire extBlocked = extAny && !extIsId
        && ((extIsPm && !extPmOk) || (extIsEe && !extEeOk));
    wire extPass = extAny && !extBlocked; // allowed external access
    // cpu takes priority on a collision; external retries
    wire cpuOwns = cpuAny; // cpu wins the array port
    wire extGo = extPass && !cpuOwns; // external forwarded this cycle

    // ******************************************************
    // user id memory
    // ******************************************************
    wire uidCpuWr = cpuReq.wr && cpuIsUid;
    wire uidExtWr = extGo && extReq.wr && extIsUid; // tool writes ids too
    wire [ADDR_W-1:0] uidAddr = uidCpuWr || (cpuReq.rd && cpuIsUid) ? cpuReq.addr
        : extReq.addr;
    wire [DATA_W-1:0] uidWdata = uidCpuWr ? cpuReq.wdata : extReq.wdata;
    logic [DATA_W-1:0] uidRdata; // registered id word
    nvmcwp_uid_mem nvmcwp_uid_mem_inst (
        .clock(clock),
        .rst(rst),
        .wrEn(uidCpuWr || uidExtWr),
        .wrIdx(uidAddr[1:0]),
        .wrData(uidWdata),
        .rdIdx(uidAddr[1:0]),
        .rdData(uidRdata)
    );

    // ******************************************************
    // forwarding to the arrays (ids never forwarded as writes)
    // ******************************************************
    nvmcwp_req_t pmReq_nxt; // next program array request
    nvmcwp_req_t eeReq_nxt; // next eeprom request
    always_comb begin
        pmReq_nxt = '0;
        eeReq_nxt = '0;
        if (cpuAny) begin
            if (cpuIsPm) begin
                pmReq_nxt = cpuReq;
                pmReq_nxt.wr = cpuPmWrOk;
            end else if (cpuIsEe) begin
                eeReq_nxt = cpuReq;
            end
        end else if (extGo) begin
            if (extIsPm) begin
                pmReq_nxt = extReq;
            end else if (extIsEe) begin
                eeReq_nxt = extReq;
            end
        end
    end

    // ******************************************************
    // answer tracking: source of the pending read
    // ******************************************************
    typedef enum logic [2:0] {SRC_NONE, SRC_PM, SRC_EE, SRC_UID, SRC_DEV, SRC_REV,
        SRC_ZERO} nvmcwp_src_t;
    nvmcwp_src_t cpuSrc_r; // cpu read source
    nvmcwp_src_t extSrc_r; // external read source
    function automatic nvmcwp_src_t srcOf(input logic [ADDR_W-1:0] a);
        if (isPm(a)) return SRC_PM;
        if (isEe(a)) return SRC_EE;
        if (isUid(a)) return SRC_UID;
        if (a == DEV_ID_ADDR) return SRC_DEV;
        if (a == REV_ID_ADDR) return SRC_REV;
        return SRC_ZERO;
    endfunction : srcOf
    wire nvmcwp_src_t extSrc_nxt = !extReq.rd ? SRC_NONE
        : extBlocked ? SRC_ZERO : extGo ? srcOf(extReq.addr) : SRC_NONE;
    wire nvmcwp_src_t cpuSrc_nxt = cpuReq.rd ? srcOf(cpuReq.addr) : SRC_NONE;
    function automatic logic [DATA_W-1:0] pick(input nvmcwp_src_t s,
        input logic [DATA_W-1:0] pm, input logic [DATA_W-1:0] ee,
        input logic [DATA_W-1:0] uid);
        case (s)
            SRC_PM: return pm;
            SRC_EE: return ee;
            SRC_UID: return uid;
            SRC_DEV: return DEV_ID_VAL;
            SRC_REV: return REV_ID_VAL;
            default: return ZERO_WORD;
        endcase
    endfunction : pick

    // ******************************************************
    // registered outputs
    // ******************************************************
    always_ff @(posedge clock) begin
        if (rst) begin
            pmReq <= '0;
            eeReq <= '0;
            cpuSrc_r <= SRC_NONE;
            extSrc_r <= SRC_NONE;
            extRdata <= ZERO_WORD;
            extRvalid <= 1'b0;
            extRefused <= 1'b0;
            cpuRdata <= ZERO_WORD;
            cpuRvalid <= 1'b0;
            cpuWrRefused <= 1'b0;
        end else begin
            pmReq <= pmReq_nxt;
            eeReq <= eeReq_nxt;
            cpuSrc_r <= cpuSrc_nxt;
            extSrc_r <= extSrc_nxt;
            extRdata <= pick(extSrc_r, pmRdata, eeRdata, uidRdata);
            extRvalid <= extSrc_r != SRC_NONE;
            extRefused <= extBlocked || (extAny && extIsId && extReq.wr);
            cpuRdata <= pick(cpuSrc_r, pmRdata, eeRdata, uidRdata);
            cpuRvalid <= cpuSrc_r != SRC_NONE;
            cpuWrRefused <= cpuReq.wr && cpuIsPm && !cpuPmWrOk;
        end
    end

    // ******************************************************
    // checks
    // ******************************************************
    sequence blockedRead_s;
        extReq.rd && extBlocked;
    endsequence
    blocked_read_zero_a: assert property (@(posedge clock) disable iff (rst)
        blockedRead_s |-> ##2 (extRvalid && extRdata == ZERO_WORD))
        else $error("blocked external read not zero");
    pm_lock_nofwd_a: assert property (@(posedge clock) disable iff (rst)
        (!cpuAny && extAny && extIsPm && !cfg_r.programProtect_n) |=> !pmReq.rd && !pmReq.wr)
        else $error("locked program access forwarded");
    cpu_pm_read_a: assert property (@(posedge clock) disable iff (rst)
        (cpuReq.rd && cpuIsPm) |=> pmReq.rd ##1 cpuRvalid)
        else $error("cpu program read not served");
    guard_block_a: assert property (@(posedge clock) disable iff (rst)
        (cpuReq.wr && cpuIsPm && cpuInGuard) |=> !pmReq.wr && cpuWrRefused)
        else $error("guarded self-write passed");
    ee_lock_nofwd_a: assert property (@(posedge clock) disable iff (rst)
        (!cpuAny && extAny && extIsEe && !cfg_r.dataProtect_n) |=> !eeReq.rd && !eeReq.wr)
        else $error("locked eeprom access forwarded");
    cpu_ee_write_a: assert property (@(posedge clock) disable iff (rst)
        (cpuReq.wr && cpuIsEe) |=> eeReq.wr)
        else $error("cpu eeprom write dropped");
    uid_readback_a: assert property (@(posedge clock) disable iff (rst)
        (cpuReq.wr && cpuIsUid) ##1 (cpuReq.rd && $past(cpuReq.addr) == cpuReq.addr
        && !cpuReq.wr) |-> ##2 (cpuRdata == $past(cpuReq.wdata, 3)))
        else $error("user id readback wrong");
    dev_id_read_a: assert property (@(posedge clock) disable iff (rst)
        (extReq.rd && extReq.addr == DEV_ID_ADDR && !cpuAny) |-> ##2 (extRdata == DEV_ID_VAL))
        else $error("device id read wrong");
    cfg_stable_a: assert property (@(posedge clock) disable iff (rst)
        !cfgLoad_r |=> $stable(cfg_r))
        else $error("configuration changed after load");
endmodule : nvmcwp_gate

// ### pkg/nvmcwp_pkg.sv
// package for the nvm code write protection gate: constants and carriers
// assumes one 125 MHz clock, synchronous active-high reset, no software registers
// Behaviour
// - program protect low blocks external program access, reads zero
// - cpu program reads never gated
// - self-write permission uses guard size only
// - data protect low blocks external eeprom access
// - cpu eeprom access never gated
// - program and data protection independent bits
// - two-bit field sizes self-write guarded block
// - four user id words readable and writable
// - device and revision id fixed, read-only
// - external tool can read ids whatever the protection, except in a cycle the cpu takes
package nvmcwp_pkg;
    // ******************************************************
    // widths and address map
    // ******************************************************
    localparam int ADDR_W = 16; // word address width
    localparam int DATA_W = 14; // nvm word width
    localparam logic [ADDR_W-1:0] USER_ID_BASE = 16'h8000; // first user id word
    localparam logic [ADDR_W-1:0] USER_ID_LAST = 16'h8003; // last user id word
    localparam logic [ADDR_W-1:0] REV_ID_ADDR = 16'h8005; // revision id word
    localparam logic [ADDR_W-1:0] DEV_ID_ADDR = 16'h8006; // device id word
    localparam logic [ADDR_W-1:0] EE_BASE = 16'hF000; // start of data eeprom window
    localparam logic [ADDR_W-1:0] EE_LAST = 16'hF0FF; // end of data eeprom window
    localparam int UID_DEPTH = 4; // user id words
    localparam logic [DATA_W-1:0] ZERO_WORD = 14'h0000; // blocked read answer
    // ******************************************************
    // self-write guard block ends (word address, exclusive)
    // ******************************************************
    localparam logic [ADDR_W-1:0] GUARD_END_0 = 16'h1000; // field 00: low half
    localparam logic [ADDR_W-1:0] GUARD_END_1 = 16'h0800; // field 01: low quarter
    localparam logic [ADDR_W-1:0] GUARD_END_2 = 16'h0200; // field 10: boot block
    localparam logic [1:0] GUARD_OFF = 2'h3; // field 11: nothing guarded
    // ******************************************************
    // identification values (arbitrary, neutral)
    // ******************************************************
    localparam logic [DATA_W-1:0] DEV_ID_VAL = 14'h1234; // arbitrary value
    localparam logic [DATA_W-1:0] REV_ID_VAL = 14'h0101; // arbitrary value
    // ******************************************************
    // carriers
    // ******************************************************
    typedef struct packed {
        logic rd; // read strobe, one cycle
        logic wr; // write strobe, one cycle
        logic [ADDR_W-1:0] addr; // word address
        logic [DATA_W-1:0] wdata; // write data
    } nvmcwp_req_t;
    typedef struct packed {
        logic programProtect_n; // low: program memory locked
        logic dataProtect_n; // low: eeprom locked
        logic [1:0] selfWriteGuardSize; // guarded block size
    } nvmcwp_cfg_t;
endpackage : nvmcwp_pkg

// ### rtl/nvmcwp_uid_mem.sv
// small register memory holding the four user id words
// assumes writes and reads come from the gate on the same clock
`timescale 1ns/100ps
module nvmcwp_uid_mem (
    input wire logic clock, // system clock
    input wire logic rst, // synchronous reset
    input wire logic wrEn, // write enable
    input wire logic [1:0] wrIdx, // write word index
    input wire logic [nvmcwp_pkg::DATA_W-1:0] wrData, // write data
    input wire logic [1:0] rdIdx, // read word index
    output logic [nvmcwp_pkg::DATA_W-1:0] rdData // registered read data
);
    import nvmcwp_pkg::*;
    logic [DATA_W-1:0] mem [UID_DEPTH]; // storage words
    // ******************************************************
    // storage and registered read port
    // ******************************************************
    always_ff @(posedge clock) begin
        if (rst) begin
            rdData <= ZERO_WORD;
        end else begin
            rdData <= mem[rdIdx];
        end
    end
    // write port
    always_ff @(posedge clock) begin
        if (wrEn) begin
            mem[wrIdx] <= wrData;
        end
    end
endmodule : nvmcwp_uid_mem

// ### tb/nvmcwp_array_model.sv
// behavioural program array and data eeprom behind the protection gate
// assumes the gate takes read data at the edge that ends the forwarded read
`timescale 1ns/100ps
module nvmcwp_array_model #(
    parameter logic [13:0] PM_MIX = 14'h2AAA, // program word = address xor this
    parameter logic [13:0] EE_MIX = 14'h15A5 // eeprom word = address xor this
) (
    input wire logic clock, // system clock
    input wire nvmcwp_pkg::nvmcwp_req_t pmReq, // forwarded program request
    input wire nvmcwp_pkg::nvmcwp_req_t eeReq, // forwarded eeprom request
    output logic [nvmcwp_pkg::DATA_W-1:0] pmRdata, // program read data
    output logic [nvmcwp_pkg::DATA_W-1:0] eeRdata // eeprom read data
);
    import nvmcwp_pkg::*;
    // ****************************************
    // read answers, stale data inverted
    // ****************************************
    logic [DATA_W-1:0] pmStale = 14'h0000; // idle program word, toggles
    logic [DATA_W-1:0] eeStale = 14'h0000; // idle eeprom word, toggles
    // idle words flip each clock so a stale word never looks valid
    always @(posedge clock) begin
        pmStale <= ~pmStale;
        eeStale <= ~eeStale;
    end
    // word stands while the forwarded read stands; the gate takes it at the next edge
    assign pmRdata = pmReq.rd ? (pmReq.addr[13:0] ^ PM_MIX) : pmStale;
    assign eeRdata = eeReq.rd ? (eeReq.addr[13:0] ^ EE_MIX) : eeStale;
endmodule : nvmcwp_array_model

// ### tb/nvmcwp_gate_bench.sv
// self-checking bench for the protection gate, one task per scenario
// assumes the array model and the design files are compiled first
`timescale 1ns/100ps
module nvmcwp_gate_bench;
    import nvmcwp_pkg::*;
    // ****************************************
    // stimulus, results and instances
    // ****************************************
    localparam logic [13:0] PM_MIX = 14'h2AAA; // model program pattern
    localparam logic [13:0] EE_MIX = 14'h15A5; // model eeprom pattern
    logic clock = 1'b0, rst = 1'b1; // clock and reset
    nvmcwp_cfg_t cfgIn = '0; // fuse bits
    nvmcwp_req_t extReq = '0, cpuReq = '0, pmReq, eeReq; // requests
    logic [13:0] pmRdata, eeRdata, extRdata, cpuRdata, gotData; // data words
    logic extRvalid, extRefused, cpuRvalid, cpuWrRefused; // answer pulses
    logic gotPm, gotEe, gotRef, gotVal; // sampled results
    int failures = 0, nTests = 0; // counters
    nvmcwp_gate nvmcwp_gate_inst (.clock(clock), .rst(rst), .cfgIn(cfgIn), .extReq(extReq),
        .cpuReq(cpuReq), .pmRdata(pmRdata), .eeRdata(eeRdata), .pmReq(pmReq), .eeReq(eeReq),
        .extRdata(extRdata), .extRvalid(extRvalid), .extRefused(extRefused),
        .cpuRdata(cpuRdata), .cpuRvalid(cpuRvalid), .cpuWrRefused(cpuWrRefused));
    nvmcwp_array_model #(.PM_MIX(PM_MIX), .EE_MIX(EE_MIX)) nvmcwp_array_model_inst (
        .clock(clock), .pmReq(pmReq), .eeReq(eeReq), .pmRdata(pmRdata), .eeRdata(eeRdata));
    initial forever #4 clock = ~clock; // 125 MHz
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check_bit(input logic got, input logic exp, input string what);
        nTests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %b", $time, what, got);
        end
    endtask : check_bit
    task automatic check_word(input logic [13:0] got, input logic [13:0] exp);
        nTests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: data %h not %h", $time, got, exp);
        end
    endtask : check_word
    // reset with new fuse bits; the first edge after release loads them
    task automatic restart(input nvmcwp_cfg_t cfg);
        @(posedge clock);
        #1 cfgIn = cfg;
        rst = 1'b1;
        repeat (4) @(posedge clock);
        #1 rst = 1'b0;
    endtask : restart
    // one request pulse, then the +1 and +2 results are judged
    task automatic access(input logic ext, input logic wr, input logic [15:0] a,
        input logic ePm, input logic eEe, input logic eRef, input logic [13:0] eData);
        nvmcwp_req_t r;
        r = '{rd: ~wr, wr: wr, addr: a, wdata: 14'h2A5C};
        @(posedge clock);
        #1 if (ext) extReq = r; else cpuReq = r;
        @(posedge clock);
        #1 extReq = '0;
        cpuReq = '0;
        gotPm = pmReq.rd | pmReq.wr;
        gotEe = eeReq.rd | eeReq.wr;
        gotRef = ext ? extRefused : cpuWrRefused;
        @(posedge clock);
        #1 gotVal = ext ? extRvalid : cpuRvalid;
        gotData = ext ? extRdata : cpuRdata;
        check_bit(gotPm, ePm, "program forward");
        check_bit(gotEe, eEe, "eeprom forward");
        check_bit(gotRef, eRef, "refusal");
        check_bit(gotVal, ~wr, "answer valid");
        if (!wr) check_word(gotData, eData);
    endtask : access
    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_open;
        restart('{1'b1, 1'b1, 2'h3});
        access(1, 0, 16'h0100, 1, 0, 0, 14'h0100 ^ PM_MIX);
        access(1, 0, DEV_ID_ADDR, 0, 0, 0, DEV_ID_VAL);
        access(1, 0, REV_ID_ADDR, 0, 0, 0, REV_ID_VAL);
        access(1, 1, DEV_ID_ADDR, 0, 0, 1, 14'h0000);
        access(0, 1, REV_ID_ADDR, 0, 0, 0, 14'h0000);
        access(0, 0, REV_ID_ADDR, 0, 0, 0, REV_ID_VAL);
        access(1, 0, DEV_ID_ADDR, 0, 0, 0, DEV_ID_VAL);
        access(0, 1, USER_ID_BASE, 0, 0, 0, 14'h0000);
        access(0, 0, USER_ID_BASE, 0, 0, 0, 14'h2A5C);
        access(0, 1, USER_ID_LAST, 0, 0, 0, 14'h0000);
        access(0, 0, USER_ID_LAST, 0, 0, 0, 14'h2A5C);
        $display("test_open finished");
    endtask : test_open
    task automatic test_pm_lock;
        restart('{1'b0, 1'b1, 2'h3});
        access(1, 0, 16'h0100, 0, 0, 1, ZERO_WORD);
        access(1, 1, 16'h0100, 0, 0, 1, ZERO_WORD);
        access(0, 0, 16'h0100, 1, 0, 0, 14'h0100 ^ PM_MIX);
        access(1, 0, EE_BASE, 0, 1, 0, EE_BASE[13:0] ^ EE_MIX);
        access(1, 0, DEV_ID_ADDR, 0, 0, 0, DEV_ID_VAL);
        access(0, 1, 16'h0000, 1, 0, 0, 14'h0000);
        $display("test_pm_lock finished");
    endtask : test_pm_lock
    task automatic test_ee_lock;
        restart('{1'b1, 1'b0, 2'h3});
        @(posedge clock); // load edge takes the fuse bits
        #1 cfgIn = '0; // fuse lines move after loading
        access(1, 0, EE_LAST, 0, 0, 1, ZERO_WORD);
        access(1, 1, EE_BASE, 0, 0, 1, ZERO_WORD);
        access(0, 0, EE_LAST, 0, 1, 0, EE_LAST[13:0] ^ EE_MIX);
        access(0, 1, EE_BASE, 0, 1, 0, 14'h0000);
        access(1, 0, 16'h0200, 1, 0, 0, 14'h0200 ^ PM_MIX);
        $display("test_ee_lock finished");
    endtask : test_ee_lock
    // each guard size: last guarded word refused, first free word written
    task automatic test_guard;
        logic [15:0] ends [3];
        ends = '{GUARD_END_0, GUARD_END_1, GUARD_END_2};
        for (int g = 0; g < 3; g++) begin
            restart('{1'b0, 1'b1, 2'(g)});
            access(0, 1, ends[g] - 16'h0001, 0, 0, 1, 14'h0000);
            access(0, 1, ends[g], 1, 0, 0, 14'h0000);
        end
        restart('{1'b1, 1'b1, GUARD_OFF});
        access(0, 1, 16'h0000, 1, 0, 0, 14'h0000);
        $display("test_guard finished");
    endtask : test_guard
    // cpu id write then read on back-to-back cycles, tool read colliding; tool id access
    task automatic test_back_to_back;
        restart('{1'b1, 1'b1, GUARD_OFF});
        @(posedge clock);
        #1 cpuReq = '{rd: 1'b0, wr: 1'b1, addr: USER_ID_BASE + 16'h0001, wdata: 14'h1C3E};
        @(posedge clock);
        #1 cpuReq = '{rd: 1'b1, wr: 1'b0, addr: USER_ID_BASE + 16'h0001, wdata: 14'h0000};
        extReq = '{rd: 1'b1, wr: 1'b0, addr: DEV_ID_ADDR, wdata: 14'h0000};
        @(posedge clock);
        #1 cpuReq = '0;
        extReq = '0;
        check_bit(extRefused, 1'b0, "collision refusal");
        @(posedge clock);
        #1 check_bit(cpuRvalid, 1'b1, "cpu id answer");
        check_word(cpuRdata, 14'h1C3E);
        check_bit(extRvalid, 1'b0, "collided tool answer");
        access(1, 1, USER_ID_LAST, 0, 0, 0, 14'h0000);
        access(1, 0, USER_ID_LAST, 0, 0, 0, 14'h2A5C);
        access(1, 1, EE_BASE, 0, 1, 0, 14'h0000);
        $display("test_back_to_back finished");
    endtask : test_back_to_back
    // ****************************************
    // verdict, main sequence and watchdog
    // ****************************************
    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", nTests, failures);
        if (failures == 0 && nTests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done
    initial begin
        test_open();
        test_pm_lock();
        test_ee_lock();
        test_guard();
        test_back_to_back();
        test_done();
    end
    // about 140 cycles expected; cut a hang at 5000
    initial begin
        #40000;
        failures++;
        $display("unexpected at %0t: watchdog expired", $time);
        test_done();
    end
endmodule : nvmcwp_gate_bench
